// File: logic/usbpm_params.svh
`ifndef USBPM_PARAMS_SVH
`define USBPM_PARAMS_SVH

// ---------------------------------------------
// clocking
// ---------------------------------------------
`define USBPM_CLK_HZ 200000000
`define USBPM_KA_HZ 100000
`define USBPM_KA_DIV (`USBPM_CLK_HZ / `USBPM_KA_HZ)

// ---------------------------------------------
// power-down control word fields
// ---------------------------------------------
`define USBPM_CLKOFF_MSB 31
`define USBPM_CLKOFF_LSB 16
`define USBPM_BLKDIS_MSB 15
`define USBPM_BLKDIS_LSB 0
`define USBPM_CLKOFF_DEF_MS 10
`define USBPM_CLKOFF_DEF_TICKS (`USBPM_CLKOFF_DEF_MS * `USBPM_KA_HZ / 1000)
`define USBPM_CLKOFF_MAX_MS 500
`define USBPM_CLKOFF_MAX_TICKS (`USBPM_CLKOFF_MAX_MS * `USBPM_KA_HZ / 1000)

// ---------------------------------------------
// mode control word fields
// ---------------------------------------------
`define USBPM_OC_MODE_BIT 15

// ---------------------------------------------
// timing
// ---------------------------------------------
`define USBPM_ENTER_MS 100
`define USBPM_ENTER_CYCLES (`USBPM_ENTER_MS * (`USBPM_CLK_HZ / 1000))
`define USBPM_CLKRDY_NS 50000
`define USBPM_CLKRDY_CYCLES (`USBPM_CLKRDY_NS / 1000 * (`USBPM_CLK_HZ / 1000000))
`define USBPM_OC_FILT_US 5000
`define USBPM_OC_FILT_CYCLES (`USBPM_OC_FILT_US * (`USBPM_CLK_HZ / 1000000))
`define USBPM_SUSP_SETTLE_TICKS 2
`define USBPM_NPORTS 3

`endif

// File: logic/usbpm_pkg.sv
package usbpm_pkg;

    // power sequencer states
    typedef enum logic [2:0]
    {
        ST_AWAKE,
        ST_ENTERING,
        ST_SUSPEND,
        ST_RESTART,
        ST_RESUME
    } usbpm_state_e;

endpackage

// File: logic/usbpm_oc_if.sv
`timescale 1ns/1ps

interface usbpm_oc_if #(
    parameter int NP = 3
);
    logic [NP-1:0] power_req;
    logic digital_mode;
    logic [NP-1:0] power_en_n;
    logic [NP-1:0] tripped;

    modport ctrl (
        output power_req,
        output digital_mode,
        input power_en_n,
        input tripped
    );

    modport guard (
        input power_req,
        input digital_mode,
        output power_en_n,
        output tripped
    );
endinterface

// File: logic/usbpm_oc_guard.sv
`timescale 1ns/1ps
`include "usbpm_params.svh"

module usbpm_oc_guard #(
    parameter int NP = `USBPM_NPORTS,
    parameter int FILT_CYCLES = `USBPM_OC_FILT_CYCLES
)(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [NP-1:0] i_port_overcurrent_in_n,
    input wire logic [NP-1:0] i_port_analog_oc,
    usbpm_oc_if.guard oc
);
    localparam int FW = $clog2(FILT_CYCLES + 1);
    localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYCLES - 1);

    // ---------------------------------------------
    // per-port filter and power switch
    // ---------------------------------------------
    genvar p;
    for (p = 0; p < NP; p++)
    begin : g_port
        logic [1:0] meta_r;
        logic [1:0] sync_r;
        logic [FW-1:0] cnt_r;
        logic [FW-1:0] cnt_nxt;
        logic trip_r;
        logic trip_nxt;
        logic en_n_r;
        logic en_n_nxt;
        logic oc_hit;

        // filter: inrush shorter than the window never trips
        always_comb
        begin
            oc_hit = oc.digital_mode ? ~sync_r[0] : sync_r[1];
            cnt_nxt = cnt_r;
            if (!oc_hit)
                cnt_nxt = '0;
            else if (cnt_r != FILT_LAST)
                cnt_nxt = cnt_r + 1'b1;
            trip_nxt = trip_r;
            if (!oc.power_req[p])
                trip_nxt = 1'b0;
            // trip wins over a release in the same cycle
            if (oc_hit && cnt_r == FILT_LAST)
                trip_nxt = 1'b1;
            en_n_nxt = ~(oc.power_req[p] & ~trip_nxt);
        end

        // bit 0 is the switch flag, bit 1 the on-chip comparator
        always_ff @(posedge i_clock or negedge i_rstn)
        begin
            if (!i_rstn)
            begin
                meta_r <= 2'b01;
                sync_r <= 2'b01;
                cnt_r <= '0;
                trip_r <= 1'b0;
                en_n_r <= 1'b1;
            end
            else
            begin
                meta_r <= {i_port_analog_oc[p], i_port_overcurrent_in_n[p]};
                sync_r <= meta_r;
                cnt_r <= cnt_nxt;
                trip_r <= trip_nxt;
                en_n_r <= en_n_nxt;
            end
        end

        assign oc.power_en_n[p] = en_n_r;
        assign oc.tripped[p] = trip_r;
    end

endmodule

// File: logic/usbpm_ctrl.sv
`timescale 1ns/1ps
`include "usbpm_params.svh"

module usbpm_ctrl #(
    parameter int NPORTS = `USBPM_NPORTS,
    parameter int ENTER_CYCLES = `USBPM_ENTER_CYCLES,
    parameter int CLKRDY_CYCLES = `USBPM_CLKRDY_CYCLES,
    parameter int OC_FILT_CYCLES = `USBPM_OC_FILT_CYCLES,
    parameter int CNT_W = 25
)(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_suspend_req,
    input wire logic i_run_stop,
    input wire logic [31:0] i_pwrdn_ctrl,
    input wire logic [31:0] i_hw_mode_ctrl,
    input wire logic i_irq_clear,
    input wire logic i_cs_n,
    input wire logic i_vcc5_on,
    input wire logic [NPORTS-1:0] i_port_connect,
    input wire logic i_host_sleep_wake_pin_in,
    input wire logic i_periph_sleep_wake_pin_in,
    input wire logic [NPORTS-1:0] i_port_overcurrent_in_n,
    input wire logic [NPORTS-1:0] i_port_analog_oc,
    input wire logic [NPORTS-1:0] i_port_power_req,
    output logic o_main_clock_en,
    output logic o_slow_keepalive_clock,
    output logic o_host_sleep_wake_pin_out,
    output logic o_host_sleep_wake_pin_oe,
    output logic o_periph_sleep_wake_pin_out,
    output logic o_periph_sleep_wake_pin_oe,
    output logic o_clocks_ready_irq,
    output logic o_host_part_on,
    output logic o_periph_part_on,
    output logic o_suspended,
    output logic o_bus_float,
    output logic [15:0] o_block_disable,
    output logic [NPORTS-1:0] o_port_power_enable_n,
    output logic [NPORTS-1:0] o_port_oc_tripped
);

    // ---------------------------------------------
    // local constants
    // ---------------------------------------------
    localparam int KA_DIV = `USBPM_KA_DIV;
    localparam int KA_W = $clog2(KA_DIV);
    localparam logic [KA_W-1:0] KA_LAST = KA_W'(KA_DIV - 1);
    localparam logic [KA_W-1:0] KA_HALF = KA_W'(KA_DIV / 2);
    localparam int SYNC_W = NPORTS + 4;
    localparam logic [SYNC_W-1:0] SYNC_RST = {4'b1111, {NPORTS{1'b0}}};
    localparam logic [15:0] HOLD_DEF = 16'(`USBPM_CLKOFF_DEF_TICKS);
    localparam logic [15:0] HOLD_MAX = 16'(`USBPM_CLKOFF_MAX_TICKS);
    localparam logic [CNT_W-1:0] ENTER_LAST = CNT_W'(ENTER_CYCLES - 1);
    localparam logic [CNT_W-1:0] CLKRDY_LAST = CNT_W'(CLKRDY_CYCLES - 1);
    localparam logic [CNT_W-1:0] SETTLE = CNT_W'(`USBPM_SUSP_SETTLE_TICKS);

    // ---------------------------------------------
    // pin synchronisers
    // ---------------------------------------------
    logic [SYNC_W-1:0] pin_meta_r;
    logic [SYNC_W-1:0] pin_sync_r;
    logic vcc5_s;
    logic cs_n_s;
    logic host_pin_s;
    logic periph_pin_s;
    logic [NPORTS-1:0] conn_s;

    // two stages; only the second stage is read below
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_meta_r <= SYNC_RST;
            pin_sync_r <= SYNC_RST;
        end
        else
        begin
            pin_meta_r <= {i_vcc5_on, i_cs_n, i_host_sleep_wake_pin_in,
                           i_periph_sleep_wake_pin_in, i_port_connect};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign vcc5_s = pin_sync_r[NPORTS + 3];
    assign cs_n_s = pin_sync_r[NPORTS + 2];
    assign host_pin_s = pin_sync_r[NPORTS + 1];
    assign periph_pin_s = pin_sync_r[NPORTS];
    assign conn_s = pin_sync_r[NPORTS-1:0];

    // ---------------------------------------------
    // keep-alive divider
    // ---------------------------------------------
    logic [KA_W-1:0] ka_cnt_r;
    logic [KA_W-1:0] ka_cnt_nxt;
    logic ka_clk_r;
    logic ka_clk_nxt;
    logic ka_tick;

    // free running from the always-on clock, so it keeps going in suspend
    always_comb
    begin
        ka_tick = (ka_cnt_r == KA_LAST);
        ka_cnt_nxt = ka_tick ? '0 : ka_cnt_r + 1'b1;
        ka_clk_nxt = (ka_cnt_nxt < KA_HALF);
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ka_cnt_r <= '0;
            ka_clk_r <= 1'b0;
        end
        else
        begin
            ka_cnt_r <= ka_cnt_nxt;
            ka_clk_r <= ka_clk_nxt;
        end
    end

    // ---------------------------------------------
    // wake source merge
    // ---------------------------------------------
    logic [NPORTS-1:0] conn_prev_r;
    logic [1:0] pend_r;
    logic [1:0] pend_nxt;
    logic conn_chg;
    logic [1:0] pin_wake;
    logic [15:0] clkoff_field;
    logic [15:0] hold_ticks;

    // short cs and hot-plug events are latched so a tick between them cannot miss one; pin wakes are only sampled on the tick
    always_comb
    begin
        conn_chg = |(conn_s ^ conn_prev_r);
        pin_wake = {~periph_pin_s, ~host_pin_s};
        clkoff_field = i_pwrdn_ctrl[`USBPM_CLKOFF_MSB:`USBPM_CLKOFF_LSB];
        if (clkoff_field == 16'h0000)
            hold_ticks = HOLD_DEF;
        else if (clkoff_field > HOLD_MAX)
            hold_ticks = HOLD_MAX;
        else
            hold_ticks = clkoff_field;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            conn_prev_r <= '0;
        end
        else
        begin
            conn_prev_r <= conn_s;
        end
    end

    // ---------------------------------------------
    // power sequencer
    // ---------------------------------------------
    usbpm_pkg::usbpm_state_e state_r;
    usbpm_pkg::usbpm_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic host_on_r;
    logic host_on_nxt;
    logic periph_on_r;
    logic periph_on_nxt;
    logic irq_r;
    logic irq_nxt;
    logic clk_en_r;
    logic clk_en_nxt;
    logic host_oe_r;
    logic host_oe_nxt;
    logic periph_oe_r;
    logic periph_oe_nxt;
    logic float_r;
    logic float_nxt;
    logic [15:0] blk_dis_r;
    logic [15:0] blk_dis_nxt;
    logic [1:0] wake_now;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        host_on_nxt = host_on_r;
        periph_on_nxt = periph_on_r;
        pend_nxt = pend_r;
        irq_nxt = irq_r & ~i_irq_clear;
        wake_now = 2'b00;
        if (state_r == usbpm_pkg::ST_SUSPEND)
        begin
            // cs low wakes both parts, a hot-plug wakes the host
            pend_nxt = pend_r | {~cs_n_s, ~cs_n_s | conn_chg};
        end
        unique case (state_r)
            usbpm_pkg::ST_AWAKE:
            begin
                host_on_nxt = 1'b1;
                periph_on_nxt = 1'b1;
                if (i_suspend_req)
                begin
                    state_nxt = usbpm_pkg::ST_ENTERING;
                    cnt_nxt = ENTER_LAST;
                end
            end
            usbpm_pkg::ST_ENTERING:
            begin
                if (!i_suspend_req)
                    state_nxt = usbpm_pkg::ST_AWAKE;
                else if (cnt_r == '0)
                begin
                    state_nxt = usbpm_pkg::ST_SUSPEND;
                    cnt_nxt = SETTLE;
                    host_on_nxt = 1'b0;
                    periph_on_nxt = 1'b0;
                    pend_nxt = 2'b00;
                end
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            usbpm_pkg::ST_SUSPEND:
            begin
                // our own low drive needs a few cycles to fade after release,
                // so the pins are only trusted after the settle ticks
                if (ka_tick)
                begin
                    if (cnt_r != '0)
                        cnt_nxt = cnt_r - 1'b1;
                    else
                        wake_now = pin_wake;
                    wake_now = wake_now | pend_r;
                    if (wake_now != 2'b00)
                    begin
                        state_nxt = usbpm_pkg::ST_RESTART;
                        cnt_nxt = CLKRDY_LAST;
                        host_on_nxt = wake_now[0];
                        periph_on_nxt = wake_now[1];
                        pend_nxt = 2'b00;
                    end
                end
            end
            usbpm_pkg::ST_RESTART:
            begin
                if (cnt_r == '0)
                begin
                    irq_nxt = 1'b1;
                    state_nxt = usbpm_pkg::ST_RESUME;
                    cnt_nxt = CNT_W'(hold_ticks);
                end
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            usbpm_pkg::ST_RESUME:
            begin
                if (i_run_stop)
                    state_nxt = usbpm_pkg::ST_AWAKE;
                else if (cnt_r == '0)
                begin
                    state_nxt = usbpm_pkg::ST_SUSPEND;
                    cnt_nxt = SETTLE;
                    host_on_nxt = 1'b0;
                    periph_on_nxt = 1'b0;
                end
                else if (ka_tick)
                    cnt_nxt = cnt_r - 1'b1;
            end
        endcase
        clk_en_nxt = (state_nxt != usbpm_pkg::ST_SUSPEND);
        // an unpowered core leaves every shared pin to the outside
        host_oe_nxt = host_on_nxt & vcc5_s;
        periph_oe_nxt = periph_on_nxt & vcc5_s;
        float_nxt = ~vcc5_s;
        blk_dis_nxt = i_pwrdn_ctrl[`USBPM_BLKDIS_MSB:`USBPM_BLKDIS_LSB];
    end

    // interrupt flop runs on the always-on clock, not the gated one
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r <= usbpm_pkg::ST_AWAKE;
            cnt_r <= '0;
            host_on_r <= 1'b1;
            periph_on_r <= 1'b1;
            pend_r <= 2'b00;
            irq_r <= 1'b0;
            clk_en_r <= 1'b1;
            host_oe_r <= 1'b0;
            periph_oe_r <= 1'b0;
            float_r <= 1'b0;
            blk_dis_r <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            host_on_r <= host_on_nxt;
            periph_on_r <= periph_on_nxt;
            pend_r <= pend_nxt;
            irq_r <= irq_nxt;
            clk_en_r <= clk_en_nxt;
            host_oe_r <= host_oe_nxt;
            periph_oe_r <= periph_oe_nxt;
            float_r <= float_nxt;
            blk_dis_r <= blk_dis_nxt;
        end
    end

    // ---------------------------------------------
    // overcurrent protection
    // ---------------------------------------------
    usbpm_oc_if #(.NP(NPORTS)) oc_bus ();

    // one mode bit serves all ports; a dual-role port 1 needs analog
    assign oc_bus.digital_mode = i_hw_mode_ctrl[`USBPM_OC_MODE_BIT];
    assign oc_bus.power_req = i_port_power_req;

    usbpm_oc_guard #(
        .NP(NPORTS),
        .FILT_CYCLES(OC_FILT_CYCLES)
    ) u_oc_guard (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_port_overcurrent_in_n(i_port_overcurrent_in_n),
        .i_port_analog_oc(i_port_analog_oc),
        .oc(oc_bus)
    );

    // ---------------------------------------------
    // outputs
    // ---------------------------------------------
    // pins only ever pull low; high comes from the external pull-up
    assign o_host_sleep_wake_pin_out = 1'b0;
    assign o_periph_sleep_wake_pin_out = 1'b0;
    assign o_host_sleep_wake_pin_oe = host_oe_r;
    assign o_periph_sleep_wake_pin_oe = periph_oe_r;
    assign o_main_clock_en = clk_en_r;
    assign o_slow_keepalive_clock = ka_clk_r;
    assign o_clocks_ready_irq = irq_r;
    assign o_host_part_on = host_on_r;
    assign o_periph_part_on = periph_on_r;
    assign o_suspended = ~clk_en_r;
    assign o_bus_float = float_r;
    assign o_block_disable = blk_dis_r;
    assign o_port_power_enable_n = oc_bus.power_en_n;
    assign o_port_oc_tripped = oc_bus.tripped;

endmodule

// File: verification/usbpm_ctrl_assertions.sv
`timescale 1ns/1ps
// ------------------------------
// sequencer and port power checks
// ------------------------------
module usbpm_ctrl_assertions #(
    parameter int NPORTS = 3,
    parameter int ENTER_CYCLES = 50,
    parameter int CLKRDY_CYCLES = 20,
    parameter int OC_FILT_CYCLES = 10
)(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_suspend_req,
    input wire logic i_run_stop,
    input wire logic [31:0] i_pwrdn_ctrl,
    input wire logic [31:0] i_hw_mode_ctrl,
    input wire logic i_irq_clear,
    input wire logic [NPORTS-1:0] i_port_overcurrent_in_n,
    input wire logic o_main_clock_en,
    input wire logic o_slow_keepalive_clock,
    input wire logic o_host_sleep_wake_pin_oe,
    input wire logic o_periph_sleep_wake_pin_oe,
    input wire logic o_clocks_ready_irq,
    input wire logic o_suspended,
    input wire logic o_bus_float,
    input wire logic [15:0] o_block_disable,
    input wire logic [NPORTS-1:0] o_port_power_enable_n,
    input wire logic [NPORTS-1:0] o_port_oc_tripped
);
    localparam int RDY_MAX = CLKRDY_CYCLES + 2;
    int req_cnt;
    int oc_cnt;
    int ka_run;
    logic ka_prev;

    // run lengths of held inputs and of each keep-alive level (fixed 1000 cycles a half period)
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            req_cnt <= 0;
            oc_cnt <= 0;
            ka_run <= 0;
            ka_prev <= 1'b0;
        end
        else
        begin
            req_cnt <= i_suspend_req ? req_cnt + 1 : 0;
            oc_cnt <= (i_hw_mode_ctrl[15] && !i_port_overcurrent_in_n[0]) ? oc_cnt + 1 : 0;
            ka_prev <= o_slow_keepalive_clock;
            ka_run <= (o_slow_keepalive_clock != ka_prev) ? 0 : ka_run + 1;
        end
    end

    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    stop_release_a: assert property ($fell(o_main_clock_en) |-> !(o_host_sleep_wake_pin_oe || o_periph_sleep_wake_pin_oe))
        else $error("wake pin still driven as clocks stop");
    keepalive_toggle_a: assert property (ka_run < 1000)
        else $error("keepalive clock stalled");
    enter_not_early_a: assert property ($fell(o_main_clock_en) && $past(i_suspend_req) |-> req_cnt >= ENTER_CYCLES)
        else $error("suspend entered too early");
    enter_not_late_a: assert property (req_cnt == ENTER_CYCLES + 1 |-> !o_main_clock_en)
        else $error("suspend entered too late");
    pins_float_a: assert property (o_suspended [*2] |-> !(o_host_sleep_wake_pin_oe || o_periph_sleep_wake_pin_oe))
        else $error("wake pin driven in suspend");
    irq_sticky_a: assert property (o_clocks_ready_irq && !i_irq_clear |=> o_clocks_ready_irq)
        else $error("clocks ready flag lost");
    irq_after_wake_a: assert property ($rose(o_main_clock_en) |-> ##[1:RDY_MAX] o_clocks_ready_irq)
        else $error("clocks ready late");
    run_keeps_awake_a: assert property (o_main_clock_en && i_run_stop && !i_suspend_req |=> o_main_clock_en)
        else $error("fell asleep with run bit set");
    oc_cut_a: assert property (oc_cnt == OC_FILT_CYCLES + 2 |-> o_port_power_enable_n[0])
        else $error("port power kept under overcurrent");
    trip_power_off_a: assert property ((o_port_oc_tripped & ~o_port_power_enable_n) == '0)
        else $error("tripped port still powered");
    float_release_a: assert property (o_bus_float [*2] |-> !(o_host_sleep_wake_pin_oe || o_periph_sleep_wake_pin_oe))
        else $error("wake pin driven with supply off");
    block_copy_a: assert property (1'b1 |=> o_block_disable == $past(i_pwrdn_ctrl[15:0]))
        else $error("block disables not copied");

    cover property ($fell(o_main_clock_en));
    cover property ($rose(o_clocks_ready_irq));
    cover property ($rose(o_port_oc_tripped[0]));
endmodule

// File: verification/usbpm_host_model.sv
`timescale 1ns/1ps
// ------------------------------
// processor side of the sleep/wake pins
// ------------------------------
module usbpm_host_model (
    input wire logic i_host_oe,
    input wire logic i_host_out,
    input wire logic i_periph_oe,
    input wire logic i_periph_out,
    input wire logic i_wake_host,
    input wire logic i_wake_periph,
    output logic o_host_wire,
    output logic o_periph_wire
);
    // pull-ups hold the wires high unless someone pulls low; gpio output mode pulls low
    assign o_host_wire = ~((i_host_oe & ~i_host_out) | i_wake_host);
    assign o_periph_wire = ~((i_periph_oe & ~i_periph_out) | i_wake_periph);
endmodule

// File: verification/usbpm_ctrl_test.sv
`timescale 1ns/1ps
module usbpm_ctrl_test;
    localparam int NP = 3;
    logic clk, rstn, susp_req, run, irq_clr, cs_n, vcc5, wake_h, wake_p, k0;
    logic h_wire, p_wire, clk_en, ka, h_out, h_oe, p_out, p_oe, irq, h_on, p_on, susp, flt;
    logic [31:0] pwrdn, mode;
    logic [NP-1:0] conn, oc_n, aoc, preq, pen_n, trip;
    logic [15:0] blk;
    logic [7:0] obs;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;

    // ------------------------------
    // design and pin partner
    // ------------------------------
    usbpm_ctrl #(.NPORTS(NP), .ENTER_CYCLES(50), .CLKRDY_CYCLES(20), .OC_FILT_CYCLES(10)) u_usbpm_ctrl (
        .i_clock(clk), .i_rstn(rstn), .i_suspend_req(susp_req), .i_run_stop(run),
        .i_pwrdn_ctrl(pwrdn), .i_hw_mode_ctrl(mode), .i_irq_clear(irq_clr), .i_cs_n(cs_n),
        .i_vcc5_on(vcc5), .i_port_connect(conn), .i_host_sleep_wake_pin_in(h_wire),
        .i_periph_sleep_wake_pin_in(p_wire), .i_port_overcurrent_in_n(oc_n), .i_port_analog_oc(aoc),
        .i_port_power_req(preq), .o_main_clock_en(clk_en), .o_slow_keepalive_clock(ka),
        .o_host_sleep_wake_pin_out(h_out), .o_host_sleep_wake_pin_oe(h_oe),
        .o_periph_sleep_wake_pin_out(p_out), .o_periph_sleep_wake_pin_oe(p_oe),
        .o_clocks_ready_irq(irq), .o_host_part_on(h_on), .o_periph_part_on(p_on), .o_suspended(susp),
        .o_bus_float(flt), .o_block_disable(blk), .o_port_power_enable_n(pen_n), .o_port_oc_tripped(trip)
    );
    usbpm_host_model u_usbpm_host_model (
        .i_host_oe(h_oe), .i_host_out(h_out), .i_periph_oe(p_oe), .i_periph_out(p_out),
        .i_wake_host(wake_h), .i_wake_periph(wake_p), .o_host_wire(h_wire), .o_periph_wire(p_wire)
    );
    // flags polled by the wait task
    assign obs = {trip[2], trip[0], flt, p_on, h_on, irq, susp, clk_en};

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard, well above the longest sequence
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            fails++;
            wrap_up();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_vec(what, {15'h0000, exp}, {15'h0000, got});
    endtask

    // bounded wait; the caller compares afterwards
    task automatic wait_obs(input int idx, input logic val, input int bound);
        for (int n = 0; n < bound && obs[idx] !== val; n++)
            step(1);
    endtask

    task automatic sleep();
        susp_req = 1'b1;
        step(40);
        check_bit("awake during entry", 1'b1, clk_en);
        wait_obs(1, 1'b1, 30);
        check_bit("suspended", 1'b1, susp);
        susp_req = 1'b0;
        step(2);
        check_bit("host pin released", 1'b0, h_oe);
        check_bit("host pin high", 1'b1, h_wire);
    endtask

    task automatic wrap_up();
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------
    // test sequence
    // ------------------------------
    initial
    begin
        rstn = 1'b0;
        susp_req = 1'b0;
        run = 1'b0;
        irq_clr = 1'b0;
        cs_n = 1'b1;
        vcc5 = 1'b1;
        wake_h = 1'b0;
        wake_p = 1'b0;
        pwrdn = 32'h0002_00A5;
        mode = 32'h0000_8000;
        conn = 3'h0;
        oc_n = 3'h7;
        aoc = 3'h0;
        preq = 3'h7;
        step(10);
        check_bit("reset clocks", 1'b1, clk_en);
        check_vec("reset power", 16'h0007, {13'h0000, pen_n});
        rstn = 1'b1;
        step(3);
        check_vec("power on", 16'h0000, {13'h0000, pen_n});
        check_vec("block disables", 16'h00A5, blk);
        check_bit("host pin low awake", 1'b0, h_wire);
        sleep();
        k0 = ka;
        step(1000);
        check_bit("keepalive toggles", ~k0, ka);
        // each wake source, then fall back after the two-tick hold
        for (int src = 0; src < 4; src++)
        begin
            case (src)
                0: wake_h = 1'b1;
                1: wake_p = 1'b1;
                2: cs_n = 1'b0;
                default: conn = 3'h1;
            endcase
            wait_obs(2, 1'b1, 20000);
            check_bit("clocks ready", 1'b1, irq);
            check_bit("main clocks", 1'b1, clk_en);
            check_bit("part on", 1'b1, src == 1 ? p_on : h_on);
            wake_h = 1'b0;
            wake_p = 1'b0;
            cs_n = 1'b1;
            irq_clr = 1'b1;
            step(1);
            irq_clr = 1'b0;
            step(1900);
            check_bit("irq cleared", 1'b0, irq);
            check_bit("resume held", 1'b1, clk_en);
            wait_obs(1, 1'b1, 2300);
            check_bit("back to suspend", 1'b1, susp);
        end
        wake_h = 1'b1;
        wait_obs(2, 1'b1, 20000);
        wake_h = 1'b0;
        run = 1'b1;
        step(5000);
        check_bit("run keeps awake", 1'b1, clk_en);
        // digital overcurrent on port 0: short glitch, then a real trip
        oc_n[0] = 1'b0;
        step(8);
        oc_n[0] = 1'b1;
        step(20);
        check_vec("inrush ignored", 16'h0000, {13'h0000, pen_n});
        oc_n[0] = 1'b0;
        wait_obs(6, 1'b1, 40);
        check_vec("digital trip", 16'h0001, {13'h0000, pen_n});
        check_vec("trip flags", 16'h0001, {13'h0000, trip});
        oc_n[0] = 1'b1;
        preq[0] = 1'b0;
        step(3);
        preq[0] = 1'b1;
        step(3);
        check_vec("power rearmed", 16'h0000, {13'h0000, pen_n});
        // analog mode ignores the switch flag
        mode = 32'h0000_0000;
        oc_n[2] = 1'b0;
        step(30);
        check_vec("flag ignored", 16'h0000, {13'h0000, pen_n});
        oc_n[2] = 1'b1;
        aoc[2] = 1'b1;
        wait_obs(7, 1'b1, 40);
        check_vec("analog trip", 16'h0004, {13'h0000, pen_n});
        aoc[2] = 1'b0;
        vcc5 = 1'b0;
        step(5);
        check_bit("bus floated", 1'b1, flt);
        check_bit("wake pin floated", 1'b0, h_oe);
        vcc5 = 1'b1;
        step(5);
        check_bit("bus driven", 1'b0, flt);
        // processor resets the core once 5 v is back; pulse kept short for run time
        rstn = 1'b0;
        step(4);
        rstn = 1'b1;
        step(3);
        check_vec("power after reset", 16'h0000, {13'h0000, pen_n});
        wrap_up();
    end
endmodule

bind usbpm_ctrl usbpm_ctrl_assertions #(.NPORTS(NPORTS), .ENTER_CYCLES(ENTER_CYCLES),
    .CLKRDY_CYCLES(CLKRDY_CYCLES), .OC_FILT_CYCLES(OC_FILT_CYCLES)) u_usbpm_ctrl_assertions (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_suspend_req(i_suspend_req), .i_run_stop(i_run_stop),
    .i_pwrdn_ctrl(i_pwrdn_ctrl), .i_hw_mode_ctrl(i_hw_mode_ctrl), .i_irq_clear(i_irq_clear),
    .i_port_overcurrent_in_n(i_port_overcurrent_in_n), .o_main_clock_en(o_main_clock_en),
    .o_slow_keepalive_clock(o_slow_keepalive_clock), .o_host_sleep_wake_pin_oe(o_host_sleep_wake_pin_oe),
    .o_periph_sleep_wake_pin_oe(o_periph_sleep_wake_pin_oe), .o_clocks_ready_irq(o_clocks_ready_irq),
    .o_suspended(o_suspended), .o_bus_float(o_bus_float), .o_block_disable(o_block_disable),
    .o_port_power_enable_n(o_port_power_enable_n), .o_port_oc_tripped(o_port_oc_tripped));
